/* shared/cpu_exception_sequencer_map.svh */
// offsets, vectors, field positions and reset values of the exception sequencer
`ifndef CPU_EXCEPTION_SEQUENCER_MAP_SVH
`define CPU_EXCEPTION_SEQUENCER_MAP_SVH

`define REG_TBP_OFF        8'h00
`define REG_EXT_LEVEL_OFF  8'h04
`define REG_STATE_OFF      8'h08
`define REG_CTRL_OFF       8'h0C

`define TBP_RESET          32'h0000_0000
`define EXT_LEVEL_RESET    32'h0000_0000
`define CTRL_RESET         32'h0000_0000

`define POR_PC_ADDR        32'h0000_0000
`define POR_SP_ADDR        32'h0000_0004
`define MAN_PC_ADDR        32'h0000_0008
`define MAN_SP_ADDR        32'h0000_000C

`define VEC_ILLEGAL_GEN    8'h04
`define VEC_ILLEGAL_SLOT   8'h06
`define VEC_CPU_ADDR_ERR   8'h09
`define VEC_DMA_ADDR_ERR   8'h0A
`define VEC_NMI            8'h0B
`define VEC_USER_BREAK     8'h0C
`define VEC_TRAP_BASE      3'h1
`define VEC_EXT_BASE       5'h08
`define VEC_MODULE_FIRST   8'h48

`define MASK_LSB           4
`define MASK_ALL_SET       4'hF
`define NMI_LEVEL          4'hF
`define STACK_STEP         32'h0000_0004
`define STACK_STEP2        32'h0000_0008
`endif

/* shared/cpu_exception_sequencer_pkg.sv */
// types shared by the exception sequencer and its neighbours
package cpu_exception_sequencer_pkg;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_HOLD    = 3'b001,
    ST_RD_PC   = 3'b010,
    ST_RD_SP   = 3'b011,
    ST_PUSH_SR = 3'b100,
    ST_PUSH_PC = 3'b101,
    ST_RD_VEC  = 3'b110
  } seq_state_t;

  typedef enum logic [1:0] {
    KIND_RESET = 2'b00,
    KIND_ADDR  = 2'b01,
    KIND_INTR  = 2'b10,
    KIND_INSN  = 2'b11
  } exc_kind_t;

  typedef struct packed {
    logic       valid;
    logic       undef;
    logic       in_slot;
    logic       pc_write;
    logic       trap;
    logic [7:0] trap_imm;
  } dec_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic [31:0] pc;
    logic [31:0] sp;
    logic [31:0] sr;
  } core_regs_t;

endpackage

/* verilog/cpu_exception_sequencer.sv */
// exception detection, arbitration and vector sequencing for the core
//
// Local design decisions: the address map and the Wishbone register port.
`timescale 1ns/1ns
`include "cpu_exception_sequencer_map.svh"

module cpu_exception_sequencer
  import cpu_exception_sequencer_pkg::*;
#(
  parameter logic [3:0] UBC_LEVEL = 4'hF
) (
  input  logic        clk_i,
  input  logic        rst_i,
  input  logic [31:0] adr_i,
  input  logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input  logic        we_i,
  input  logic [3:0]  sel_i,
  input  logic        cyc_i,
  input  logic        stb_i,
  output logic        ack_o,
  input  logic        chip_clear_pin_n_i,
  input  logic        nmi_pin_i,
  input  logic [7:0]  external_request_line_i,
  input  logic        nmi_req_i,
  input  logic        ubc_req_i,
  input  logic        mod_req_i,
  input  logic [7:0]  mod_vector_i,
  input  logic [3:0]  mod_level_i,
  input  logic        cpu_addr_err_i,
  input  logic        dma_addr_err_i,
  input  dec_t        dec_i,
  input  logic        exec_done_i,
  input  logic        bus_busy_i,
  input  core_regs_t  core_i,
  output mem_req_t    mem_o,
  input  logic        mem_ack_i,
  input  logic [31:0] mem_rdata_i,
  output logic        exc_active_o,
  output logic        intr_ack_o,
  output logic [7:0]  intr_vector_o,
  output logic        pc_load_o,
  output logic        sp_load_o,
  output logic        sr_load_o,
  output core_regs_t  core_o
);

  // pin synchronisers: three stages, a change counts when stages two and three agree
  logic [2:0]  clr_sync_q;
  logic [2:0]  nmi_sync_q;
  logic [7:0]  ext_s1_q;
  logic [7:0]  ext_s2_q;
  logic [7:0]  ext_s3_q;
  logic        clr_level_q;
  logic        nmi_level_q;
  logic [7:0]  ext_level_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clr_sync_q <= 3'h7;
      nmi_sync_q <= 3'h7;
      ext_s1_q   <= 8'h00;
      ext_s2_q   <= 8'h00;
      ext_s3_q   <= 8'h00;
    end else begin
      clr_sync_q <= {clr_sync_q[1:0], chip_clear_pin_n_i};
      nmi_sync_q <= {nmi_sync_q[1:0], nmi_pin_i};
      ext_s1_q   <= external_request_line_i;
      ext_s2_q   <= ext_s1_q;
      ext_s3_q   <= ext_s2_q;
    end
  end

  wire clr_agree = clr_sync_q[1] == clr_sync_q[2];
  wire nmi_agree = nmi_sync_q[1] == nmi_sync_q[2];
  wire [7:0] ext_agree = ~(ext_s2_q ^ ext_s3_q);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clr_level_q <= 1'b1;
      nmi_level_q <= 1'b1;
      ext_level_q <= 8'h00;
    end else begin
      clr_level_q <= clr_agree ? clr_sync_q[2] : clr_level_q;
      nmi_level_q <= nmi_agree ? nmi_sync_q[2] : nmi_level_q;
      ext_level_q <= (ext_agree & ext_s3_q) | (~ext_agree & ext_level_q);
    end
  end

  wire clr_low  = clr_agree & ~clr_sync_q[2];
  wire clr_rise = clr_agree & clr_sync_q[2] & ~clr_level_q;

  // software registers
  logic [31:0] tbp_q;
  logic [31:0] ext_lvl_q;
  logic [31:0] ctrl_q;
  logic        ack_q;
  logic [31:0] rdat_q;

  wire        bus_req   = cyc_i & stb_i & ~ack_q;
  wire [7:0]  bus_off   = adr_i[7:0];
  wire        hit_tbp   = bus_off == `REG_TBP_OFF;
  wire        hit_lvl   = bus_off == `REG_EXT_LEVEL_OFF;
  wire        hit_state = bus_off == `REG_STATE_OFF;
  wire        hit_ctrl  = bus_off == `REG_CTRL_OFF;
  // a write lands at the edge where the master samples ack, not when it is first seen
  wire        bus_wr    = cyc_i & stb_i & ack_q & we_i;
  wire [31:0] sel_mask  = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};

  // sequencer state
  seq_state_t  state_q;
  exc_kind_t   kind_q;
  logic        rst_pend_q;
  logic        rst_manual_q;
  logic        cpu_ae_q;
  logic        dma_ae_q;
  logic [7:0]  vec_q;
  logic [3:0]  lvl_q;
  logic [31:0] sp_base_q;
  logic [31:0] pc_snap_q;
  logic [31:0] sr_snap_q;
  logic [31:0] new_pc_q;
  mem_req_t    mem_q;
  logic        pc_load_q;
  logic        sp_load_q;
  logic        sr_load_q;
  core_regs_t  core_q;
  logic        intr_ack_q;
  logic [7:0]  intr_vec_q;

  wire [31:0] state_word = {8'h00, vec_q, lvl_q, 3'h0, rst_manual_q,
                            kind_q, dma_ae_q, cpu_ae_q, 1'b0, state_q};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q  <= bus_req;
      rdat_q <= hit_tbp   ? tbp_q :
                hit_lvl   ? ext_lvl_q :
                hit_state ? state_word :
                hit_ctrl  ? ctrl_q : 32'h0000_0000;
    end
  end

  assign ack_o = ack_q;
  assign dat_o = rdat_q;

  // interrupt selection: nmi, then user break, then highest level request
  wire [3:0] cur_mask = core_i.sr[`MASK_LSB +: 4];
  logic       ext_hit;
  logic [2:0] ext_idx;
  logic [3:0] ext_lvl;

  always_comb begin
    ext_hit = 1'b0;
    ext_idx = 3'h0;
    ext_lvl = 4'h0;
    for (int i = 0; i < 8; i++) begin
      if (ext_level_q[i] && ext_lvl_q[4*i +: 4] > cur_mask &&
          (!ext_hit || ext_lvl_q[4*i +: 4] > ext_lvl)) begin
        ext_hit = 1'b1;
        ext_idx = 3'(i);
        ext_lvl = ext_lvl_q[4*i +: 4];
      end
    end
  end

  wire mod_ok  = mod_req_i & (mod_level_i > cur_mask) & (mod_vector_i >= `VEC_MODULE_FIRST);
  wire ubc_ok  = ubc_req_i & (UBC_LEVEL > cur_mask);
  // module beats a line only on a strictly higher level
  wire mod_win = mod_ok & (!ext_hit || mod_level_i > ext_lvl);
  wire intr_ok = nmi_req_i | ubc_ok | ext_hit | mod_ok;
  wire [7:0] intr_vec = nmi_req_i ? `VEC_NMI :
                        ubc_ok    ? `VEC_USER_BREAK :
                        mod_win   ? mod_vector_i : {`VEC_EXT_BASE, ext_idx};
  wire [3:0] intr_lvl = nmi_req_i ? `NMI_LEVEL :
                        ubc_ok    ? UBC_LEVEL :
                        mod_win   ? mod_level_i : ext_lvl;

  wire ill_gen  = dec_i.valid & dec_i.undef & ~dec_i.in_slot;
  wire ill_slot = dec_i.valid & dec_i.in_slot & (dec_i.undef | dec_i.pc_write);
  wire trap_now = dec_i.valid & dec_i.trap & ~dec_i.in_slot;
  // trap vector range; reserved never issued
  wire [7:0] trap_vec = {`VEC_TRAP_BASE, dec_i.trap_imm[4:0]};
  wire [7:0] insn_vec = ill_slot ? `VEC_ILLEGAL_SLOT :
                        ill_gen  ? `VEC_ILLEGAL_GEN : trap_vec;
  wire insn_ok = ill_slot | ill_gen | trap_now;

  // manual reset deferred behind bus cycle
  wire rst_go  = rst_pend_q & ~(rst_manual_q & bus_busy_i);
  wire ae_go   = exec_done_i & (cpu_ae_q | dma_ae_q);
  wire intr_go = exec_done_i & intr_ok;

  wire take_rst  = (state_q == ST_IDLE) & rst_go;
  wire take_ae   = (state_q == ST_IDLE) & ~rst_pend_q & ae_go;
  wire take_intr = (state_q == ST_IDLE) & ~rst_pend_q & ~ae_go & intr_go;
  wire take_insn = (state_q == ST_IDLE) & ~rst_pend_q & ~ae_go & ~intr_go & insn_ok;

  wire [7:0]  ae_vec   = cpu_ae_q ? `VEC_CPU_ADDR_ERR : `VEC_DMA_ADDR_ERR;
  wire [31:0] vec_addr = tbp_q + {22'h000000, vec_q, 2'b00};
  wire        mem_done = mem_q.req & mem_ack_i;
  // mask kept unless interrupt; level into mask
  wire [3:0]  new_mask = (kind_q == KIND_INTR) ? lvl_q : sr_snap_q[`MASK_LSB +: 4];
  wire [31:0] sr_out   = (sr_snap_q & ~(32'h0000_000F << `MASK_LSB)) |
                         ({28'h0000000, new_mask} << `MASK_LSB);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tbp_q     <= `TBP_RESET;
      ext_lvl_q <= `EXT_LEVEL_RESET;
      ctrl_q    <= `CTRL_RESET;
    end else begin
      if (bus_wr) begin
        tbp_q     <= hit_tbp ? (tbp_q & ~sel_mask) | (dat_i & sel_mask) : tbp_q;
        ext_lvl_q <= hit_lvl ? (ext_lvl_q & ~sel_mask) | (dat_i & sel_mask) : ext_lvl_q;
        ctrl_q    <= hit_ctrl ? (ctrl_q & ~sel_mask) | (dat_i & sel_mask) : ctrl_q;
      end
      if (state_q == ST_RD_SP && mem_done && !clr_low) begin
        tbp_q <= 32'h0000_0000;
      end
    end
  end

  // address error flags: a new error wins over the clear by acceptance
  always_ff @(posedge clk_i) begin
    if (rst_i || clr_low) begin
      cpu_ae_q <= 1'b0;
      dma_ae_q <= 1'b0;
    end else begin
      cpu_ae_q <= cpu_addr_err_i | (cpu_ae_q & ~take_ae);
      dma_ae_q <= dma_addr_err_i | (dma_ae_q & ~(take_ae & ~cpu_ae_q));
    end
  end

  // reset request: rst_i itself behaves as a power-on reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rst_pend_q   <= 1'b1;
      rst_manual_q <= 1'b0;
    end else if (clr_rise) begin
      // power-on on high; manual on low
      rst_pend_q   <= 1'b1;
      rst_manual_q <= ~nmi_level_q;
    end else if (take_rst) begin
      rst_pend_q   <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q    <= ST_IDLE;
      kind_q     <= KIND_RESET;
      vec_q      <= 8'h00;
      lvl_q      <= 4'h0;
      sp_base_q  <= 32'h0000_0000;
      pc_snap_q  <= 32'h0000_0000;
      sr_snap_q  <= 32'h0000_0000;
      new_pc_q   <= 32'h0000_0000;
      mem_q      <= '0;
      pc_load_q  <= 1'b0;
      sp_load_q  <= 1'b0;
      sr_load_q  <= 1'b0;
      core_q     <= '0;
      intr_ack_q <= 1'b0;
      intr_vec_q <= 8'h00;
    end else begin
      pc_load_q  <= 1'b0;
      sp_load_q  <= 1'b0;
      sr_load_q  <= 1'b0;
      intr_ack_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (clr_low) begin
            state_q <= ST_HOLD;
          end else if (take_rst) begin
            kind_q  <= KIND_RESET;
            state_q <= ST_RD_PC;
            sr_snap_q <= core_i.sr;
            // power-on pc; manual pc; no base
            mem_q   <= '{req: 1'b1, we: 1'b0, wdata: 32'h0000_0000,
                         addr: rst_manual_q ? `MAN_PC_ADDR : `POR_PC_ADDR};
          end else if (take_ae || take_intr || take_insn) begin
            kind_q    <= take_ae ? KIND_ADDR : take_intr ? KIND_INTR : KIND_INSN;
            vec_q     <= take_ae ? ae_vec : take_intr ? intr_vec : insn_vec;
            lvl_q     <= intr_lvl;
            sp_base_q <= core_i.sp;
            pc_snap_q <= core_i.pc;
            sr_snap_q <= core_i.sr;
            intr_ack_q <= take_intr;
            intr_vec_q <= intr_vec;
            state_q   <= ST_PUSH_SR;
            mem_q     <= '{req: 1'b1, we: 1'b1, addr: core_i.sp - `STACK_STEP,
                           wdata: core_i.sr};
          end
        end
        ST_HOLD: begin
          // chip clear held low: nothing runs until its rising edge
          mem_q <= '0;
          if (!clr_low) begin
            state_q <= ST_IDLE;
          end
        end
        ST_RD_PC: begin
          if (clr_low) begin
            state_q <= ST_HOLD;
          end else if (mem_done) begin
            new_pc_q <= mem_rdata_i;
            state_q  <= ST_RD_SP;
            mem_q    <= '{req: 1'b1, we: 1'b0, wdata: 32'h0000_0000,
                          addr: rst_manual_q ? `MAN_SP_ADDR : `POR_SP_ADDR};
          end
        end
        ST_RD_SP: begin
          if (clr_low) begin
            state_q <= ST_HOLD;
          end else if (mem_done) begin
            // mask to 1111 and start at loaded pc
            core_q.pc <= new_pc_q;
            core_q.sp <= mem_rdata_i;
            core_q.sr <= sr_snap_q | ({28'h0000000, `MASK_ALL_SET} << `MASK_LSB);
            pc_load_q <= 1'b1;
            sp_load_q <= 1'b1;
            sr_load_q <= 1'b1;
            mem_q     <= '0;
            state_q   <= ST_IDLE;
          end
        end
        ST_PUSH_SR: begin
          if (clr_low) begin
            state_q <= ST_HOLD;
          end else if (mem_done) begin
            mem_q   <= '{req: 1'b1, we: 1'b1, addr: sp_base_q - `STACK_STEP2,
                         wdata: pc_snap_q};
            state_q <= ST_PUSH_PC;
          end
        end
        ST_PUSH_PC: begin
          if (clr_low) begin
            state_q <= ST_HOLD;
          end else if (mem_done) begin
            mem_q   <= '{req: 1'b1, we: 1'b0, addr: vec_addr, wdata: 32'h0000_0000};
            state_q <= ST_RD_VEC;
          end
        end
        ST_RD_VEC: begin
          if (clr_low) begin
            state_q <= ST_HOLD;
          end else if (mem_done) begin
            core_q.pc <= mem_rdata_i;
            core_q.sp <= sp_base_q - `STACK_STEP2;
            core_q.sr <= sr_out;
            pc_load_q <= 1'b1;
            sp_load_q <= 1'b1;
            sr_load_q <= 1'b1;
            mem_q     <= '0;
            state_q   <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          mem_q   <= '0;
        end
      endcase
    end
  end

  // the pipeline stalls while a sequence, a pending reset or a held clear exists
  assign exc_active_o  = (state_q != ST_IDLE) | rst_pend_q | clr_low;
  assign mem_o         = mem_q;
  assign pc_load_o     = pc_load_q;
  assign sp_load_o     = sp_load_q;
  assign sr_load_o     = sr_load_q;
  assign core_o        = core_q;
  assign intr_ack_o    = intr_ack_q;
  assign intr_vector_o = intr_vec_q;

endmodule

/* test/cpu_exception_sequencer_props.sv */
// port assertions for the exception sequencer
`timescale 1ns/1ns
module exc_seq_props
  import cpu_exception_sequencer_pkg::*;
(
  input logic        clk_i,
  input logic        rst_i,
  input logic        exec_done_i,
  input core_regs_t  core_i,
  input mem_req_t    mem_o,
  input logic        mem_ack_i,
  input logic [31:0] mem_rdata_i,
  input logic        intr_ack_o,
  input logic [7:0]  intr_vector_o,
  input logic        pc_load_o,
  input logic        sp_load_o,
  input logic        sr_load_o,
  input core_regs_t  core_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic vec_q;
  wire rst_rd = mem_o.req && !mem_o.we && (mem_o.addr == 32'h0 || mem_o.addr == 32'h8);
  wire sp_rd  = mem_o.req && !mem_o.we && (mem_o.addr == 32'h4 || mem_o.addr == 32'hC);
  wire sr_wr  = mem_o.req && mem_o.we && mem_o.addr == core_i.sp - 32'h4;
  wire pc_wr  = mem_o.req && mem_o.we && mem_o.addr == core_i.sp - 32'h8;
  sequence sr_push_done; sr_wr && mem_ack_i; endsequence
  sequence pc_push_done; pc_wr && mem_ack_i; endsequence
  // a chip clear in mid-vector read would leave this set; benches avoid that
  always_ff @(posedge clk_i) begin
    if (rst_i) vec_q <= 1'b0;
    else if (pc_wr && mem_ack_i) vec_q <= 1'b1;
    else if (mem_ack_i) vec_q <= 1'b0;
  end
  AST_POR_START: assert property (
    $fell(rst_i) |=> mem_o.req && !mem_o.we && mem_o.addr == 32'h0) else $error("no pc read");
  AST_RESET_PAIR: assert property (
    rst_rd && mem_ack_i |=> mem_o.req && !mem_o.we && mem_o.addr == $past(mem_o.addr) + 32'h4)
    else $error("sp read not after pc read");
  AST_RESET_LOAD: assert property (
    sp_rd && mem_ack_i |=> pc_load_o && sp_load_o && core_o.sp == $past(mem_rdata_i)
      && core_o.sr[7:4] == 4'hF && !mem_o.req) else $error("reset load wrong");
  AST_PUSH_SR: assert property (
    $rose(mem_o.req) && mem_o.we |-> sr_wr && mem_o.wdata == core_i.sr)
    else $error("status push wrong");
  AST_PUSH_PC: assert property (
    sr_push_done |=> pc_wr && mem_o.wdata == core_i.pc) else $error("pc push wrong");
  AST_VEC_READ: assert property (
    pc_push_done |=> mem_o.req && !mem_o.we && mem_o.addr[1:0] == 2'h0)
    else $error("no vector read");
  AST_HANDLER: assert property (
    vec_q && mem_ack_i |=> pc_load_o && sr_load_o && core_o.pc == $past(mem_rdata_i)
      && core_o.sp == core_i.sp - 32'h8) else $error("handler load wrong");
  AST_INTR_PUSH: assert property (
    intr_ack_o |-> $rose(mem_o.req) && mem_o.we && $past(exec_done_i))
    else $error("interrupt taken mid instruction");
  AST_INTR_VEC: assert property (
    intr_ack_o |-> intr_vector_o inside {8'h0B, 8'h0C} || intr_vector_o >= 8'h40)
    else $error("reserved vector issued");
endmodule

bind cpu_exception_sequencer exc_seq_props exc_seq_props_i (
  .clk_i(clk_i), .rst_i(rst_i), .exec_done_i(exec_done_i), .core_i(core_i), .mem_o(mem_o),
  .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i), .intr_ack_o(intr_ack_o),
  .intr_vector_o(intr_vector_o), .pc_load_o(pc_load_o), .sp_load_o(sp_load_o),
  .sr_load_o(sr_load_o), .core_o(core_o));

/* test/exc_mem_model.sv */
// memory partner answering the sequencer's requests
`timescale 1ns/1ns
module exc_mem_model
  import cpu_exception_sequencer_pkg::*;
(
  input  logic        clk_i,
  input  logic        rst_i,
  input  mem_req_t    mem_i,
  input  logic [3:0]  dly_i,
  output logic        ack_o,
  output logic [31:0] rdata_o
);
  logic [31:0] mem [256];
  logic [3:0]  cnt_q;
  initial for (int i = 0; i < 256; i++) mem[i] = 32'h8000_0000 + (i << 4);
  // idle read data flips every cycle so a stale sample never matches
  always @(posedge clk_i) begin
    if (rst_i || !mem_i.req || ack_o) begin
      if (ack_o && mem_i.req && mem_i.we) mem[mem_i.addr[9:2]] <= mem_i.wdata;
      ack_o   <= 1'b0;
      cnt_q   <= 4'h0;
      rdata_o <= rst_i ? 32'h5A5A_A5A5 : ~rdata_o;
    end else if (cnt_q >= dly_i) begin
      ack_o   <= 1'b1;
      rdata_o <= mem[mem_i.addr[9:2]];
    end else begin
      cnt_q   <= cnt_q + 4'h1;
      rdata_o <= ~rdata_o;
    end
  end
endmodule

/* test/cpu_exception_sequencer_bench.sv */
// self-checking bench for the exception sequencer
`timescale 1ns/1ns
module cpu_exception_sequencer_bench;
  import cpu_exception_sequencer_pkg::*;
  localparam core_regs_t CORE = '{pc: 32'h0000_2468, sp: 32'h0000_0400, sr: 32'h0000_0013};
  logic        clk_i, rst_i, we, cyc, stb, ack, clr_n, npin, nmi, ubc, mreq_in, cae, dae;
  logic        done, busy, mack, iack, pcl, spl, srl, act;
  logic [31:0] adr, dat, dout, rd, mrdata;
  logic [7:0]  ext, mvec, ivec;
  logic [3:0]  mlvl, dly;
  dec_t        dec;
  mem_req_t    mreq;
  core_regs_t  cout;
  int          fail_count, cmp_count;

  cpu_exception_sequencer cpu_exception_sequencer_i (
    .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(dat), .dat_o(dout), .we_i(we),
    .sel_i(4'hF), .cyc_i(cyc), .stb_i(stb), .ack_o(ack), .chip_clear_pin_n_i(clr_n),
    .nmi_pin_i(npin), .external_request_line_i(ext), .nmi_req_i(nmi), .ubc_req_i(ubc),
    .mod_req_i(mreq_in), .mod_vector_i(mvec), .mod_level_i(mlvl), .cpu_addr_err_i(cae),
    .dma_addr_err_i(dae), .dec_i(dec), .exec_done_i(done), .bus_busy_i(busy), .core_i(CORE),
    .mem_o(mreq), .mem_ack_i(mack), .mem_rdata_i(mrdata), .exc_active_o(act),
    .intr_ack_o(iack), .intr_vector_o(ivec), .pc_load_o(pcl), .sp_load_o(spl),
    .sr_load_o(srl), .core_o(cout));
  exc_mem_model exc_mem_model_i (.clk_i(clk_i), .rst_i(rst_i), .mem_i(mreq), .dly_i(dly),
    .ack_o(mack), .rdata_o(mrdata));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  function automatic logic [31:0] pat(input logic [31:0] a);
    return 32'h8000_0000 + (a << 2);
  endfunction

  task automatic test_done;
    $display("fail_count=%0d cmp_count=%0d", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, exp, got);
    end
  endtask

  task automatic lim(input int n);
    if (n >= 300) begin
      fail_count++;
      $display("[ERR] wait timed out");
      test_done;
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {24'h0, a}; dat <= d;
    n = 0;
    do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && n < 300);
    rd = dout;
    cyc <= 1'b0; stb <= 1'b0;
    lim(n);
  endtask

  // k 0: push started, k 1: loads pulsed
  task automatic waitc(input int k);
    int n;
    n = 0;
    do begin @(posedge clk_i); n++; end
    while (!(k == 0 ? (mreq.req === 1'b1 && mreq.we === 1'b1) : pcl === 1'b1) && n < 300);
    lim(n);
  endtask

  task automatic reset_check(input logic np);
    waitc(1);
    chk("reset pc", cout.pc, pat(np ? 32'h0 : 32'h8));
    chk("reset sp", cout.sp, pat(np ? 32'h4 : 32'hC));
    chk("reset mask", {28'h0, cout.sr[7:4]}, 32'hF);
    wb(1'b0, 8'h00, 32'h0);
    chk("base cleared", rd, 32'h0);
  endtask

  task automatic rst_seq(input logic np, input logic bz);
    @(posedge clk_i);
    npin <= np; busy <= bz; clr_n <= 1'b0;
    repeat (8) @(posedge clk_i);
    clr_n <= 1'b1;
    if (bz) begin
      repeat (12) @(posedge clk_i);
      chk("deferred", {31'h0, mreq.req}, 32'h0);
      chk("stall", {31'h0, act}, 32'h1);
      busy <= 1'b0;
    end
    reset_check(np);
  endtask

  task automatic setdec(input logic u, input logic s, input logic p, input logic t,
                        input logic [7:0] imm);
    @(posedge clk_i);
    dec <= '{valid: 1'b1, undef: u, in_slot: s, pc_write: p, trap: t, trap_imm: imm};
  endtask

  task automatic pulse_ae(input logic d);
    @(posedge clk_i);
    if (d) dae <= 1'b1; else cae <= 1'b1;
    @(posedge clk_i);
    cae <= 1'b0; dae <= 1'b0;
  endtask

  // stack slots are wiped first so an old push cannot pass for a new one
  task automatic exc(input logic [7:0] v, input logic [3:0] m);
    exc_mem_model_i.mem[255] = 32'h0;
    exc_mem_model_i.mem[254] = 32'h0;
    waitc(0);
    dec <= '0; nmi <= 1'b0; ubc <= 1'b0; mreq_in <= 1'b0; ext <= 8'h00;
    waitc(1);
    chk("handler", cout.pc, pat(32'h40 + {22'h0, v, 2'h0}));
    chk("stack", cout.sp, CORE.sp - 32'h8);
    chk("mask", {28'h0, cout.sr[7:4]}, {28'h0, m});
    chk("sr push", exc_mem_model_i.mem[255], CORE.sr);
    chk("pc push", exc_mem_model_i.mem[254], CORE.pc);
    if (m != 4'h1) chk("intr vector", {24'h0, ivec}, {24'h0, v});
    repeat (4) @(posedge clk_i);
  endtask

  initial begin
    fail_count = 0; cmp_count = 0;
    rst_i = 1'b1; we = 1'b0; cyc = 1'b0; stb = 1'b0; adr = 32'h0; dat = 32'h0;
    clr_n = 1'b1; npin = 1'b1; nmi = 1'b0; ubc = 1'b0; mreq_in = 1'b0; cae = 1'b0;
    dae = 1'b0; done = 1'b1; busy = 1'b0; ext = 8'h00; mvec = 8'h00; mlvl = 4'h0;
    dly = 4'h0; dec = '0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    reset_check(1'b1);
    wb(1'b1, 8'h0C, 32'hC3A5_5A3C); wb(1'b0, 8'h0C, 32'h0);
    chk("scratch", rd, 32'hC3A5_5A3C);
    wb(1'b0, 8'h40, 32'h0);
    chk("unmapped", rd, 32'h0);
    wb(1'b1, 8'h00, 32'h40); wb(1'b1, 8'h04, 32'h3333_3333);
    setdec(1, 0, 0, 0, 8'h00); exc(8'h04, 4'h1);
    setdec(1, 1, 0, 0, 8'h00); exc(8'h06, 4'h1);
    setdec(0, 1, 1, 0, 8'h00); exc(8'h06, 4'h1);
    setdec(0, 0, 0, 1, 8'h05); exc(8'h25, 4'h1);
    setdec(0, 0, 0, 1, 8'h1F); exc(8'h3F, 4'h1);
    pulse_ae(1'b0); exc(8'h09, 4'h1);
    dly <= 4'h3;
    pulse_ae(1'b1); exc(8'h0A, 4'h1);
    @(posedge clk_i);
    done <= 1'b0; nmi <= 1'b1;
    repeat (10) @(posedge clk_i);
    chk("held off", {31'h0, mreq.req}, 32'h0);
    done <= 1'b1;
    exc(8'h0B, 4'hF);
    @(posedge clk_i); ubc <= 1'b1; exc(8'h0C, 4'hF);
    // the error pulse is latched one edge before it competes with the others
    pulse_ae(1'b0);
    nmi <= 1'b1; dec <= '{valid: 1'b1, undef: 1'b1, default: '0};
    exc(8'h09, 4'h1);
    setdec(1, 0, 0, 0, 8'h00); nmi <= 1'b1; exc(8'h0B, 4'hF);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_i);
      ext <= 8'h01 << i; dly <= i[0] ? 4'h3 : 4'h0;
      exc(8'h40 + 8'(i), 4'h3);
    end
    @(posedge clk_i); mvec <= 8'h50; mlvl <= 4'h5; mreq_in <= 1'b1;
    exc(8'h50, 4'h5);
    rst_seq(1'b1, 1'b0);
    rst_seq(1'b0, 1'b1);
    test_done;
  end
endmodule
